// ### sim/cable_far_end.sv
// Far end of the cable: drives the receive pairs of the line side
`timescale 1ns/100ps
module cable_far_end (
  input wire logic [3:0] far_p_in, // Far station positive, A..D
  input wire logic [3:0] far_n_in, // Far station negative, A..D
  input wire logic [3:0] line_tx_p_in, // Our transmit positive
  input wire logic [3:0] line_tx_n_in, // Our transmit negative
  output logic [3:0] line_rx_p_out, // Receive positive, A..D
  output logic [3:0] line_rx_n_out // Receive negative, A..D
);
  // Pairs are driven at all times, so no line is left floating
  assign line_rx_p_out = far_p_in;
  assign line_rx_n_out = far_n_in;
endmodule : cable_far_end

// ### sim/mdi_channel_mirror_tb.sv
// Self-checking bench for the line-side channel mirror block
`timescale 1ns/100ps
module mdi_channel_mirror_tb;
  logic clock_in = 1'b0; // Core clock
  logic reset_in = 1'b1; // Held for 20 cycles
  logic strap = 1'b0, gig = 1'b0, mdix = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [3:0] tx_p = 4'h0, tx_n = 4'h0, far_p = 4'h0, far_n = 4'h0;
  logic [3:0] rx_p, rx_n, ltx_p, ltx_n, crx_p, crx_n; // Line and core
  logic [15:0] addr = 16'h0000, wdata = 16'h0000, status = 16'h0000;
  logic [15:0] rdata, tctl; // Read data, tuning control
  logic act; // Mirror active
  int errors = 0;
  int checked = 0;
  mdi_channel_mirror u_dut (.clock_in(clock_in), .reset_in(reset_in),
    .strap_mirror_in(strap), .speed_gig_in(gig), .mdix_in(mdix),
    .core_tx_p_in(tx_p), .core_tx_n_in(tx_n), .line_rx_p_in(rx_p),
    .line_rx_n_in(rx_n), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .tuning_status_in(status),
    .reg_rdata_out(rdata), .tuning_control_out(tctl),
    .mirror_active_out(act), .line_tx_p_out(ltx_p), .line_tx_n_out(ltx_n),
    .core_rx_p_out(crx_p), .core_rx_n_out(crx_n));
  cable_far_end u_far (.far_p_in(far_p), .far_n_in(far_n),
    .line_tx_p_in(ltx_p), .line_tx_n_in(ltx_n), .line_rx_p_out(rx_p),
    .line_rx_n_out(rx_n));
  // Clock, 50 ns period
  initial begin
    forever #25 clock_in = ~clock_in;
  end
  task check(input string name, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, e, g);
    end
  endtask : check
  // Channel order reversal A..D to D..A
  function automatic logic [3:0] rev(input logic [3:0] x);
    return {x[0], x[1], x[2], x[3]};
  endfunction : rev
  task reg_wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clock_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock_in);
    wr <= 1'b0;
  endtask : reg_wr
  // Data lands at the taking edge, so look just after it
  task reg_rd(input logic [15:0] a, input logic [15:0] e, input string n);
    @(posedge clock_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock_in);
    rd <= 1'b0;
    #1 check(n, e, rdata);
  endtask : reg_rd
  // Sweep every pattern through both directions
  task line_chk(input logic m);
    for (int v = 0; v < 16; v++) begin
      @(posedge clock_in);
      tx_p <= v[3:0];
      tx_n <= v[3:0] ^ 4'h6;
      far_p <= ~v[3:0];
      far_n <= v[3:0] ^ 4'h9;
      @(posedge clock_in);
      #1 check("line_tx_p", 16'(m ? rev(tx_n) : tx_p), 16'(ltx_p));
      check("line_tx_n", 16'(m ? rev(tx_p) : tx_n), 16'(ltx_n));
      check("core_rx_p", 16'(m ? rev(far_n) : far_p), 16'(crx_p));
      check("core_rx_n", 16'(m ? rev(far_p) : far_n), 16'(crx_n));
      check("mirror_active", 16'(m), 16'(act));
    end
  endtask : line_chk
  task tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish
  // Hang guard, far beyond the few hundred cycles needed
  initial begin
    #250000;
    errors++;
    tally_and_finish;
  end
  initial begin
    repeat (20) @(posedge clock_in);
    reset_in <= 1'b0;
    reg_rd(mdi_mirror_pkg::PORT_CONFIG_FOUR_ADDR, 16'h0000,
      "port_cfg_rst");
    reg_rd(mdi_mirror_pkg::TUNING_CONTROL_ADDR, 16'h0000, "tctl_rst");
    line_chk(1'b0);
    reg_wr(mdi_mirror_pkg::PORT_CONFIG_FOUR_ADDR, 16'h0001);
    // Every speed and crossover setting keeps the same map
    for (int s = 0; s < 4; s++) begin
      gig <= s[1];
      mdix <= s[0];
      line_chk(1'b1);
    end
    reg_rd(mdi_mirror_pkg::PORT_CONFIG_FOUR_ADDR, 16'h8001,
      "port_cfg");
    reg_wr(mdi_mirror_pkg::PORT_CONFIG_FOUR_ADDR, 16'hFFFE);
    reg_rd(mdi_mirror_pkg::PORT_CONFIG_FOUR_ADDR, 16'h7FFE,
      "port_cfg_ro");
    line_chk(1'b0);
    // Software fix-up for 100 Mbps: swap the two status fields
    status <= 16'h1A05;
    reg_rd(mdi_mirror_pkg::TUNING_STATUS_ADDR, 16'h1A05, "tstat");
    reg_wr(mdi_mirror_pkg::TUNING_CONTROL_ADDR, 16'h051A);
    reg_wr(mdi_mirror_pkg::TUNING_STATUS_ADDR, 16'hFFFF);
    reg_rd(mdi_mirror_pkg::TUNING_CONTROL_ADDR, 16'h051A, "tctl");
    check("tctl_out", 16'h051A, tctl);
    reg_rd(16'h0077, 16'h0000, "unmapped");
    // Strap alone turns mirroring on across a second reset
    strap <= 1'b1;
    reset_in <= 1'b1;
    repeat (20) @(posedge clock_in);
    reset_in <= 1'b0;
    reg_rd(mdi_mirror_pkg::PORT_CONFIG_FOUR_ADDR, 16'h8000,
      "port_cfg_strap");
    check("tctl_rst2", 16'h0000, tctl);
    line_chk(1'b1);
    tally_and_finish;
  end
endmodule : mdi_channel_mirror_tb

// ### verilog/channel_mapper.sv
// Combinational channel order and polarity remap for one direction
`timescale 1ns/100ps
module channel_mapper #(
  parameter int CHAN_N = 4 // Channel count
) (
  input wire logic [CHAN_N-1:0] pos_in, // Positive lines by channel
  input wire logic [CHAN_N-1:0] neg_in, // Negative lines by channel
  input wire logic mirror_in, // Mirroring in effect
  output logic [CHAN_N-1:0] pos_out, // Remapped positive lines
  output logic [CHAN_N-1:0] neg_out // Remapped negative lines
);
  // One slice per channel; order reversal gives A-D, B-C, C-B, D-A
  for (genvar i = 0; i < CHAN_N; i++) begin : g_chan
    // Crossed pair feeds opposite polarity when mirrored
    assign pos_out[i] = mirror_in ? neg_in[CHAN_N-1-i] : pos_in[i];
    assign neg_out[i] = mirror_in ? pos_in[CHAN_N-1-i] : neg_in[i];
  end
endmodule : channel_mapper

// ### verilog/mdi_channel_mirror.sv
// Line-side channel mirror with its configuration registers
`timescale 1ns/100ps
module mdi_channel_mirror (
  input wire logic clock_in, // Core clock, 20 MHz
  input wire logic reset_in, // Synchronous reset, active high
  input wire logic strap_mirror_in, // Mirror strap level
  input wire logic speed_gig_in, // High in gigabit operation
  input wire logic mdix_in, // Crossover setting, no effect on mirror
  input wire logic [3:0] core_tx_p_in, // Core transmit positive, A..D
  input wire logic [3:0] core_tx_n_in, // Core transmit negative, A..D
  input wire logic [3:0] line_rx_p_in, // Line receive positive, A..D
  input wire logic [3:0] line_rx_n_in, // Line receive negative, A..D
  input wire logic [15:0] reg_addr_in, // Register address
  input wire logic [15:0] reg_wdata_in, // Register write data
  input wire logic reg_wr_in, // Write strobe
  input wire logic reg_rd_in, // Read strobe
  input wire logic [15:0] tuning_status_in, // Tuning status from analog
  output logic [15:0] reg_rdata_out, // Read data, one cycle after strobe
  output logic [15:0] tuning_control_out, // Tuning control to analog
  output logic mirror_active_out, // Mirroring in effect
  output logic [3:0] line_tx_p_out, // Line transmit positive, A..D
  output logic [3:0] line_tx_n_out, // Line transmit negative, A..D
  output logic [3:0] core_rx_p_out, // Core receive positive, A..D
  output logic [3:0] core_rx_n_out // Core receive negative, A..D
);
  // Whole block state, registered as one word
  typedef struct packed {
    logic [15:0] port_cfg; // Port config four
    logic [15:0] tune_ctl; // Tuning control
    logic strap; // Captured strap level
    logic strap_done; // Strap captured since reset
    logic active; // Mirroring in effect
    logic [15:0] rdata; // Read return
    logic [3:0] tx_p; // Line transmit positive
    logic [3:0] tx_n; // Line transmit negative
    logic [3:0] rx_p; // Core receive positive
    logic [3:0] rx_n; // Core receive negative
  } state_t;

  state_t state_reg; // Current state
  state_t state_next; // Next state
  logic [3:0] tx_p_map; // Mapper results, transmit
  logic [3:0] tx_n_map;
  logic [3:0] rx_p_map; // Mapper results, receive
  logic [3:0] rx_n_map;
  logic unused_inputs; // Speed and crossover do not alter the map
  logic mirror_now; // Enable as seen this cycle

  assign unused_inputs = speed_gig_in ^ mdix_in;
  // Strap counts at once, before its capture, to avoid a glitch
  assign mirror_now = (state_reg.strap_done ? state_reg.strap
                       : strap_mirror_in)
                      | state_reg.port_cfg[mdi_mirror_pkg::MIRROR_EN_BIT];

  // Same mapper for both directions keeps pins consistent
  channel_mapper #(.CHAN_N(mdi_mirror_pkg::CHAN_N)) u_tx_map (
    .pos_in(core_tx_p_in),
    .neg_in(core_tx_n_in),
    .mirror_in(mirror_now),
    .pos_out(tx_p_map),
    .neg_out(tx_n_map)
  );
  channel_mapper #(.CHAN_N(mdi_mirror_pkg::CHAN_N)) u_rx_map (
    .pos_in(line_rx_p_in),
    .neg_in(line_rx_n_in),
    .mirror_in(mirror_now),
    .pos_out(rx_p_map),
    .neg_out(rx_n_map)
  );

  // Next-state logic: strap capture, register access, remap
  always_comb begin
    state_next = state_reg;
    // Strap caught on the first edge after reset release
    if (!state_reg.strap_done) begin
      state_next.strap = strap_mirror_in;
      state_next.strap_done = 1'b1;
    end
    // Writes; status register is read-only and ignores them
    if (reg_wr_in) begin
      if (reg_addr_in == mdi_mirror_pkg::PORT_CONFIG_FOUR_ADDR) begin
        state_next.port_cfg = reg_wdata_in & mdi_mirror_pkg::CONFIG_WR_MASK;
      end else if (reg_addr_in == mdi_mirror_pkg::TUNING_CONTROL_ADDR) begin
        state_next.tune_ctl = reg_wdata_in;
      end
    end
    // Reads; unmapped addresses return zero
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        mdi_mirror_pkg::PORT_CONFIG_FOUR_ADDR: begin
          state_next.rdata = state_reg.port_cfg;
          state_next.rdata[mdi_mirror_pkg::MIRROR_ACT_BIT] = state_reg.active;
        end
        mdi_mirror_pkg::TUNING_CONTROL_ADDR: begin
          state_next.rdata = state_reg.tune_ctl;
        end
        mdi_mirror_pkg::TUNING_STATUS_ADDR: begin
          state_next.rdata = tuning_status_in;
        end
        default: begin
          state_next.rdata = 16'h0000;
        end
      endcase
    end
    state_next.active = mirror_now;
    // Registered remap; full reversal also covers the 10/100 pairs
    state_next.tx_p = tx_p_map;
    state_next.tx_n = tx_n_map;
    state_next.rx_p = rx_p_map;
    state_next.rx_n = rx_n_map;
  end

  // State register with synchronous reset
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      state_reg <= '{port_cfg: mdi_mirror_pkg::PORT_CONFIG_FOUR_RST,
                     tune_ctl: mdi_mirror_pkg::TUNING_CONTROL_RST,
                     default: '0};
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from the state word
  assign reg_rdata_out = state_reg.rdata;
  assign tuning_control_out = state_reg.tune_ctl;
  assign mirror_active_out = state_reg.active;
  assign line_tx_p_out = state_reg.tx_p;
  assign line_tx_n_out = state_reg.tx_n;
  assign core_rx_p_out = state_reg.rx_p;
  assign core_rx_n_out = state_reg.rx_n;

  // Channel order reversal for the checks below, kept apart from the
  // mapper so a slip in its index arithmetic cannot hide itself
  function automatic logic [3:0] lane_rev(input logic [3:0] x);
    return {x[0], x[1], x[2], x[3]};
  endfunction : lane_rev

  // Checks on the remap, the enable path and register access
  // Remap checks skip the release edge: outputs there still hold the
  // reset value while the strap may already raise the enable
  // Gigabit order on transmit: D from A, A from D, C from B
  a_gig_order_tx: assert property (@(posedge clock_in)
    disable iff (reset_in)
    (!reset_in && mirror_now) |=> line_tx_p_out[3] == $past(core_tx_n_in[0])
      && line_tx_p_out[0] == $past(core_tx_n_in[3])
      && line_tx_p_out[2] == $past(core_tx_n_in[1]))
    else $error("Mirrored transmit order wrong");
  // Low speeds keep the same A-D and B-C pairing
  a_low_speed_map: assert property (@(posedge clock_in)
    disable iff (reset_in)
    (!reset_in && mirror_now && !speed_gig_in)
    |=> line_tx_n_out[3] == $past(core_tx_p_in[0])
      && line_tx_n_out[2] == $past(core_tx_p_in[1]))
    else $error("10/100 mirror map wrong");
  // Config bit shows as active two edges after the write
  a_cfg_enables: assert property (@(posedge clock_in)
    disable iff (reset_in)
    (reg_wr_in && reg_addr_in == mdi_mirror_pkg::PORT_CONFIG_FOUR_ADDR
     && reg_wdata_in[mdi_mirror_pkg::MIRROR_EN_BIT])
    |=> ##1 mirror_active_out)
    else $error("Config bit did not enable mirror");
  // A captured strap alone keeps mirroring on
  a_strap_enables: assert property (@(posedge clock_in)
    disable iff (reset_in)
    (state_reg.strap_done && state_reg.strap) |=> mirror_active_out)
    else $error("Strap did not enable mirror");
  // Active flag tracks the enable one edge later
  a_active_follows: assert property (@(posedge clock_in)
    disable iff (reset_in)
    !reset_in |=> mirror_active_out == $past(mirror_now))
    else $error("Active flag lags the enable");
  // Polarity swaps on every crossed pair
  a_polarity_swap: assert property (@(posedge clock_in)
    disable iff (reset_in)
    (!reset_in && mirror_now)
    |=> line_tx_n_out == lane_rev($past(core_tx_p_in)))
    else $error("Mirror polarity not swapped");
  // Tuning control takes the written word whole
  a_tune_write: assert property (@(posedge clock_in)
    disable iff (reset_in)
    (reg_wr_in && reg_addr_in == mdi_mirror_pkg::TUNING_CONTROL_ADDR)
    |=> tuning_control_out == $past(reg_wdata_in))
    else $error("Tuning control write lost");
  // Status reads return the live analog word
  a_status_read: assert property (@(posedge clock_in)
    disable iff (reset_in)
    (reg_rd_in && reg_addr_in == mdi_mirror_pkg::TUNING_STATUS_ADDR)
    |=> reg_rdata_out == $past(tuning_status_in))
    else $error("Tuning status read wrong");
  // Status is read-only: a write there leaves control alone
  a_status_ignored: assert property (@(posedge clock_in)
    disable iff (reset_in)
    (reg_wr_in && reg_addr_in == mdi_mirror_pkg::TUNING_STATUS_ADDR)
    |=> tuning_control_out == $past(tuning_control_out))
    else $error("Write to status disturbed control");
  // Read data stands until the next read
  a_rdata_hold: assert property (@(posedge clock_in)
    disable iff (reset_in)
    (!reset_in && !reg_rd_in) |=> $stable(reg_rdata_out))
    else $error("Read data changed without a read");
  // Addresses outside the block read as zero
  a_unmapped_zero: assert property (@(posedge clock_in)
    disable iff (reset_in)
    (reg_rd_in && reg_addr_in != mdi_mirror_pkg::PORT_CONFIG_FOUR_ADDR
     && reg_addr_in != mdi_mirror_pkg::TUNING_CONTROL_ADDR
     && reg_addr_in != mdi_mirror_pkg::TUNING_STATUS_ADDR)
    |=> reg_rdata_out == 16'h0000)
    else $error("Unmapped read not zero");
  // Receive direction uses the very same map
  a_rx_same_map: assert property (@(posedge clock_in)
    disable iff (reset_in)
    (!reset_in && mirror_now)
    |=> core_rx_p_out == lane_rev($past(line_rx_n_in))
      && core_rx_n_out == lane_rev($past(line_rx_p_in)))
    else $error("Receive remap differs from transmit");
  // Without mirroring both directions pass straight
  a_normal_pass: assert property (@(posedge clock_in)
    disable iff (reset_in)
    (!reset_in && !mirror_now) |=> line_tx_p_out == $past(core_tx_p_in)
      && core_rx_n_out == $past(line_rx_n_in))
    else $error("Normal mode not straight through");

  // Main scenarios: strap, config bit at gigabit, fix-up access, low
  // speed with crossover, and mirroring switched back off
  c_strap_mirror: cover property (@(posedge clock_in) disable iff (reset_in)
    state_reg.strap_done && state_reg.strap);
  c_cfg_mirror: cover property (@(posedge clock_in) disable iff (reset_in)
    !state_reg.strap && state_reg.port_cfg[0] && speed_gig_in);
  c_tune_fixup: cover property (@(posedge clock_in) disable iff (reset_in)
    (reg_rd_in && reg_addr_in == mdi_mirror_pkg::TUNING_STATUS_ADDR)
    ##[1:20]
    (reg_wr_in && reg_addr_in == mdi_mirror_pkg::TUNING_CONTROL_ADDR));
  c_low_speed_mdix: cover property (@(posedge clock_in) disable iff (reset_in)
    mirror_now && !speed_gig_in && mdix_in);
  c_mirror_off: cover property (@(posedge clock_in) disable iff (reset_in)
    $fell(mirror_active_out));
endmodule : mdi_channel_mirror

// ### verilog/mdi_mirror_pkg.sv
// Constants shared by the line-side channel mirror block
package mdi_mirror_pkg;
  localparam int ADDR_W = 16; // Register address width
  localparam int DATA_W = 16; // Register data width
  localparam int CHAN_N = 4; // Twisted-pair channels A..D
  localparam logic [15:0] PORT_CONFIG_FOUR_ADDR = 16'h0031;
  localparam logic [15:0] TUNING_CONTROL_ADDR = 16'h00A0;
  localparam logic [15:0] TUNING_STATUS_ADDR = 16'h00A1;
  localparam int MIRROR_EN_BIT = 0; // Port mirror enable in config four
  localparam int MIRROR_ACT_BIT = 15; // Read-only: mirroring in effect
  localparam logic [15:0] PORT_CONFIG_FOUR_RST = 16'h0000;
  localparam logic [15:0] TUNING_CONTROL_RST = 16'h0000;
  localparam logic [15:0] CONFIG_WR_MASK = 16'h7FFF; // Active bit is RO
endpackage : mdi_mirror_pkg
